// file: bench/ptvl_chk.sv
// Checker of the trip voting outputs and register bus timing
`timescale 1ns/10ps
`default_nettype none
module ptvl_chk (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] mode_i,
	input wire logic [3:0] vu_byp_i,
	input wire logic [3:0] div_reset_i,
	input wire logic [3:0] trip_test_n_i,
	input wire logic [3:0] reset_perm_i,
	input wire logic [1:0] man_scram_n_i,
	input wire logic [3:0] ld_trip_n_o,
	input wire logic [3:0] relay_coil_o,
	input wire logic sol_a_o,
	input wire logic sol_b_o,
	input wire logic [1:0] dump_sol_o,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	import ptvl_pkg::*;
	// ****************************************************************
	// Sequences
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Manual demand on one group, switch or shutdown mode
	sequence man_s(g);
		(!man_scram_n_i[g] || mode_i == 2'h0);
	endsequence
	// Group cut and both dumps energized three edges later
	sequence scram_s(sol);
		##3 (!sol && dump_sol_o == 2'h3);
	endsequence
	// ****************************************************************
	// Assertions
	// ****************************************************************
	reset_safe_a: assert property ($rose(rst_n_i) |-> ld_trip_n_o == 4'h0 && !sol_a_o)
		else $error("outputs not tripped after reset");
	sol_vote_a: assert property ($countones(~ld_trip_n_o) >= 2 |=> !sol_a_o && !sol_b_o)
		else $error("two open drivers left solenoids on");
	dump_vote_a: assert property ($countones(~relay_coil_o) >= 2 |=> dump_sol_o == 2'h3)
		else $error("two dropped coils gave no dump");
	man_group_a: assert property (man_s(0) |-> scram_s(sol_a_o))
		else $error("manual scram did not cut group a");
	man_other_a: assert property (man_s(1) |-> scram_s(sol_b_o))
		else $error("manual scram did not cut group b");
	test_trip_a: assert property (trip_test_n_i != 4'hf && vu_byp_i == 4'h0 |->
		##4 (ld_trip_n_o & ~$past(trip_test_n_i, 4)) == 4'h0)
		else $error("trip test did not open drivers");
	seal_hold_a: assert property (((ld_trip_n_o & ~$past(ld_trip_n_o))
		& ~$past(div_reset_i & reset_perm_i, 4)) == 4'h0)
		else $error("seal cleared without permitted reset");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule
bind ptvl_top ptvl_chk i_chk (.clk_i, .rst_n_i, .mode_i, .vu_byp_i, .div_reset_i,
	.trip_test_n_i, .reset_perm_i, .man_scram_n_i, .ld_trip_n_o, .relay_coil_o,
	.sol_a_o, .sol_b_o, .dump_sol_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// file: bench/ptvl_plant_model.sv
// Behavioural sensor multiplexers feeding the channel comparators
`timescale 1ns/10ps
`default_nettype none
module ptvl_plant_model (
	input wire logic clk_i,
	input wire logic [255:0] want_val_i,
	input wire logic [3:0] want_alive_i,
	output logic [255:0] chan_value_o,
	output logic [3:0] chan_alive_o
);
	import ptvl_pkg::*;
	logic [255:0] last_reg; // Last word of each live channel
	// Remember what every answering channel sent
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < 4; c++) begin
			if (want_alive_i[c]) begin
				last_reg[c*64 +: 64] <= want_val_i[c*64 +: 64];
			end
		end
	end
	// A lost channel drops its flag and shows a flipped stale word
	always_comb begin
		chan_alive_o = want_alive_i;
		for (int c = 0; c < 4; c++) begin
			chan_value_o[c*64 +: 64] = want_alive_i[c] ? want_val_i[c*64 +: 64]
				: ~last_reg[c*64 +: 64];
		end
	end
endmodule
`default_nettype wire

// file: bench/test_protection_trip_voting_logic.sv
// Self-checking bench of the protection trip voting logic
`timescale 1ns/10ps
`default_nettype none
module test_protection_trip_voting_logic;
	import ptvl_pkg::*;
	// ****************************************************************
	// Signals and model state
	// ****************************************************************
	logic clk_i, rst_n_i, sol_a_o, sol_b_o, irq_o;
	logic [255:0] want_val, chan_value_i;
	logic [3:0] want_alive, chan_alive_i, nm_trip_n_i, msl_byp_i, vu_byp_i, div_reset_i;
	logic [3:0] trip_test_n_i, reset_perm_i, ld_trip_n_o, relay_coil_o, s_axi_wstrb;
	logic [15:0] sens_byp_i;
	logic [1:0] mode_i, man_scram_n_i, dump_sol_o, s_axi_bresp, s_axi_rresp, rr, m;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] seal_m, old_m, vh, bh, dir_m; // Model seals and bypasses
	logic [5:0] stat_m, en_m; // Model sticky events and enables
	logic [15:0] x;
	int err_count, n_tests, cyc, n, cz;
	int sp[4]; // Setpoint of each variable
	ptvl_plant_model i_plant (.clk_i, .want_val_i(want_val), .want_alive_i(want_alive),
		.chan_value_o(chan_value_i), .chan_alive_o(chan_alive_i));
	ptvl_top i_dut (.clk_i, .rst_n_i, .chan_value_i, .chan_alive_i, .nm_trip_n_i, .mode_i,
		.sens_byp_i, .msl_byp_i, .vu_byp_i, .div_reset_i, .trip_test_n_i, .reset_perm_i,
		.man_scram_n_i, .ld_trip_n_o, .relay_coil_o, .sol_a_o, .sol_b_o, .dump_sol_o,
		.irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Clock and hang guard
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	// Next pseudo-random word
	function automatic logic [31:0] nx();
		r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
		return r;
	endfunction
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Register write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ka, kw, ta, tw;
		ka = 1'b0;
		kw = 1'b0;
		@(posedge clk_i);
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ka && kw)) begin
			@(negedge clk_i);
			ta = s_axi_awready;
			tw = s_axi_wready;
			@(posedge clk_i);
			ka |= ta;
			kw |= tw;
			if (ka) s_axi_awvalid <= 1'b0;
			if (kw) s_axi_wvalid <= 1'b0;
		end
		do @(negedge clk_i); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		@(posedge clk_i);
		s_axi_bready <= 1'b0;
	endtask
	// Register read
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk_i); while (!s_axi_arready);
		@(posedge clk_i);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk_i); while (!s_axi_rvalid);
		rd_d = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge clk_i);
		s_axi_rready <= 1'b0;
	endtask
	// Verdict
	task automatic finish_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{clk_i, rst_n_i, err_count, n_tests, cyc, r} = {2'b00, 96'h0, 32'h4a5756ac};
		{want_val, want_alive, nm_trip_n_i, msl_byp_i, s_axi_wstrb} = {{256{1'b1}}, 16'hff0f};
		{vu_byp_i, div_reset_i, reset_perm_i, sens_byp_i, trip_test_n_i} = {28'h0, 4'hf};
		{mode_i, man_scram_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h1f << 3;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 98'h0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		chk("ld", {relay_coil_o, ld_trip_n_o}, 8'h00);
		rd(PTVL_STATUS_OFS);
		chk("status", rd_d, 32'h000000cf);
		rd(8'h40);
		chk("rdata", rd_d, PTVL_ZERO_WORD);
		chk("rresp", rr, PTVL_RESP_SLVERR);
		rd(PTVL_IRQ_CLR_OFS);
		chk("rresp", rr, PTVL_RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk("bresp", rr, PTVL_RESP_SLVERR);
		for (int v = 0; v < 4; v++) begin
			sp[v] = 4096 * (v + 1);
			wr(PTVL_SETPT_OFS + 8'(4 * v), sp[v]);
			rd(PTVL_SETPT_OFS + 8'(4 * v));
			chk("setpoint", rd_d, sp[v]);
		end
		dir_m = nx();
		wr(PTVL_TRIP_DIR_OFS, {28'h0, dir_m});
		rd(PTVL_TRIP_DIR_OFS);
		chk("dir", rd_d[3:0], dir_m);
		// Sync stages start at zero: loss and shutdown events are latched after reset
		{stat_m, seal_m} = 10'h30f;
		for (int i = 0; i < 60; i++) begin
			en_m = nx();
			wr(PTVL_IRQ_EN_OFS, {26'h0, en_m});
			chk("bresp", rr, PTVL_RESP_OKAY);
			@(posedge clk_i);
			want_alive <= (r[9:6] == 4'h0) ? ~(4'h1 << r[11:10]) : 4'hf;
			mode_i <= r[13:12];
			man_scram_n_i <= ~(r[15:14] & r[17:16] & r[19:18]);
			trip_test_n_i <= ~(r[23:20] & r[27:24] & r[31:28]);
			r = nx();
			vu_byp_i <= r[3:0] & r[7:4];
			div_reset_i <= r[11:8] | r[15:12];
			reset_perm_i <= r[19:16] | r[23:20];
			r = nx();
			sens_byp_i <= r[15:0] & r[31:16];
			r = nx();
			nm_trip_n_i <= ~(r[3:0] & r[7:4] & r[11:8]);
			msl_byp_i <= r[15:12];
			for (int k = 0; k < 16; k++) begin
				r = nx();
				n = (r[2:0] == 3'h0) ? 0 : (dir_m[k%4] ? -1 - r[10:3] : 1 + r[10:3]);
				want_val[k*16 +: 16] <= 16'(sp[k%4] + n);
			end
			repeat (10) @(negedge clk_i);
			old_m = seal_m;
			vh = ($countones(vu_byp_i) <= 1) ? vu_byp_i : 4'h0;
			m = (mode_i == PTVL_MODE_SHUTDOWN) ? 2'h3 : ~man_scram_n_i;
			for (int d = 0; d < 4; d++) begin
				bh = ($countones(sens_byp_i[d*4 +: 4]) == 1) ? sens_byp_i[d*4 +: 4] : 4'h0;
				cz = 0;
				for (int v = 0; v < 4; v++) begin
					n = 0;
					for (int c = 0; c < 4; c++) begin
						x = want_val[(c*4+v)*16 +: 16];
						if (!bh[c] && (!want_alive[c] || (dir_m[v] ? x >= sp[v] : x <= sp[v])))
							n++;
					end
					if (n >= 2 && !(v == PTVL_MSL_VAR && msl_byp_i[d] && mode_i != PTVL_MODE_RUN))
						cz = 1;
				end
				if ($countones(~nm_trip_n_i) >= 2) cz = 1;
				if ((cz || !trip_test_n_i[d]) && !vh[d]) seal_m[d] = 1'b1;
				else if (div_reset_i[d] && reset_perm_i[d]) seal_m[d] = 1'b0;
			end
			stat_m |= {want_alive != 4'hf, m != 2'h0, seal_m & ~old_m};
			n = $countones(seal_m);
			x = {(n >= 2 || m != 2'h0) ? 2'h3 : 2'h0, n < 2 && !m[1], n < 2 && !m[0], seal_m};
			chk("outputs", {dump_sol_o, sol_b_o, sol_a_o, relay_coil_o, ld_trip_n_o},
				{x[7:4], ~seal_m, ~seal_m});
			chk("irq", irq_o, |(stat_m & en_m));
			rd(PTVL_STATUS_OFS);
			chk("status", rd_d, {24'h0, x[7:0]});
			rd(PTVL_IRQ_STAT_OFS);
			chk("irq_stat", rd_d, {26'h0, stat_m});
			wr(PTVL_IRQ_CLR_OFS, 32'h3f);
			stat_m = {want_alive != 4'hf, m != 2'h0, 4'h0};
			repeat (3) @(negedge clk_i);
			chk("irq", irq_o, |(stat_m & en_m));
		end
		finish_test();
	end
endmodule
`default_nettype wire

// file: verilog/ptvl_pkg.sv
// Package of constants and types for the protection trip voting logic
`default_nettype none
package ptvl_pkg;
	// ****************************************************************
	// Structure sizes
	// ****************************************************************
	localparam int PTVL_NDIV = 4; // Redundant divisions
	localparam int PTVL_NCH = 4; // Sensor channels
	localparam int PTVL_NVAR_DEF = 4; // Monitored variables per channel
	localparam int PTVL_VW_DEF = 16; // Width of a digitized value
	localparam int PTVL_NMAN = 2; // Manual scram divisions
	localparam int PTVL_NIRQ = 6; // Interrupt sources
	localparam int PTVL_AW = 8; // Decoded register address bits
	localparam int PTVL_MSL_VAR = 0; // Variable index of steamline isolation

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [PTVL_AW-1:0] PTVL_STATUS_OFS = 8'h00; // Trip and output state
	localparam logic [PTVL_AW-1:0] PTVL_IRQ_STAT_OFS = 8'h04; // Sticky events
	localparam logic [PTVL_AW-1:0] PTVL_IRQ_EN_OFS = 8'h08; // Event enables
	localparam logic [PTVL_AW-1:0] PTVL_IRQ_CLR_OFS = 8'h0c; // Write one to clear
	localparam logic [PTVL_AW-1:0] PTVL_TRIP_DIR_OFS = 8'h10; // 1: trip on high value
	localparam logic [PTVL_AW-1:0] PTVL_SETPT_OFS = 8'h20; // First setpoint word

	// ****************************************************************
	// Status and interrupt bit positions
	// ****************************************************************
	localparam int PTVL_ST_SEAL = 0; // Four sealed division trips
	localparam int PTVL_ST_SOL_A = 4; // A solenoid group energized
	localparam int PTVL_ST_SOL_B = 5; // B solenoid group energized
	localparam int PTVL_ST_DUMP = 6; // Two air dump solenoids energized
	localparam int PTVL_IRQ_MAN = 4; // Manual scram active
	localparam int PTVL_IRQ_LOSS = 5; // A channel lost its input

	// ****************************************************************
	// Bus answers and reset values
	// ****************************************************************
	localparam logic [1:0] PTVL_RESP_OKAY = 2'h0; // Normal answer
	localparam logic [1:0] PTVL_RESP_SLVERR = 2'h2; // Unmapped address
	localparam logic [31:0] PTVL_ZERO_WORD = 32'h0000_0000; // Read filler

	// Operating modes as presented by the mode switch
	typedef enum logic [1:0] {
		PTVL_MODE_SHUTDOWN = 2'h0,
		PTVL_MODE_REFUEL = 2'h1,
		PTVL_MODE_STARTUP = 2'h2,
		PTVL_MODE_RUN = 2'h3
	} ptvl_mode_t;
endpackage
`default_nettype wire

// file: verilog/ptvl_top.sv
// Four-division protection trip voting logic with AXI4-Lite registers
// Summary of operation
// - Lost input or power gives trip state
// - Trips active low, bypasses active high
// - Four divisions, two manual scram divisions
// - Automatic scram uses two-of-four division voting
// - Manual path independent of automatic path
// - Compare each variable, bit to all divisions
// - Three keylock bypasses in each division
// - Per-channel bypass bits to voting unit
// - Voting unit bypass goes to output unit
// - Voting uses mode, trips and bypasses
// - Voting takes bypasses, channels, neutron monitors
// - Output unit: trip, seal-in, reset, test
// - Output unit drives its division actuators
// - Low input opens load driver, solenoids off
// - Load drivers form two two-of-four arrangements
// - Dump relays de-energized energize dump, two-of-four
// - Manual scram: own group, both dumps
`timescale 1ns/10ps
`default_nettype none
module ptvl_top #(
	parameter int NVAR = ptvl_pkg::PTVL_NVAR_DEF,
	parameter int VW = ptvl_pkg::PTVL_VW_DEF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ptvl_pkg::PTVL_NCH*NVAR*VW-1:0] chan_value_i,
	input wire logic [ptvl_pkg::PTVL_NCH-1:0] chan_alive_i,
	input wire logic [ptvl_pkg::PTVL_NDIV-1:0] nm_trip_n_i,
	input wire logic [1:0] mode_i,
	input wire logic [ptvl_pkg::PTVL_NDIV*ptvl_pkg::PTVL_NCH-1:0] sens_byp_i,
	input wire logic [ptvl_pkg::PTVL_NDIV-1:0] msl_byp_i,
	input wire logic [ptvl_pkg::PTVL_NDIV-1:0] vu_byp_i,
	input wire logic [ptvl_pkg::PTVL_NDIV-1:0] div_reset_i,
	input wire logic [ptvl_pkg::PTVL_NDIV-1:0] trip_test_n_i,
	input wire logic [ptvl_pkg::PTVL_NDIV-1:0] reset_perm_i,
	input wire logic [ptvl_pkg::PTVL_NMAN-1:0] man_scram_n_i,
	output logic [ptvl_pkg::PTVL_NDIV-1:0] ld_trip_n_o,
	output logic [ptvl_pkg::PTVL_NDIV-1:0] relay_coil_o,
	output logic sol_a_o,
	output logic sol_b_o,
	output logic [1:0] dump_sol_o,
	output logic irq_o,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ptvl_pkg::*;

	localparam int ND = PTVL_NDIV; // Division count
	localparam int NC = PTVL_NCH; // Channel count

	// ****************************************************************
	// State types
	// ****************************************************************
	// One synchroniser stage of every pin
	typedef struct packed {
		logic [NC*NVAR*VW-1:0] val; // Digitized values
		logic [NC-1:0] alive; // Channel input present
		logic [ND-1:0] nm_n; // Neutron monitor trips
		logic [1:0] mode; // Mode switch
		logic [ND*NC-1:0] sbyp; // Channel sensor bypass keys
		logic [ND-1:0] mbyp; // Steamline special bypass keys
		logic [ND-1:0] vbyp; // Voting unit bypass keys
		logic [ND-1:0] rst; // Division reset switches
		logic [ND-1:0] test_n; // Trip test switches
		logic [ND-1:0] perm; // Reset permissives
		logic [PTVL_NMAN-1:0] man_n; // Manual scram switches
	} ptvl_pins_t;

	// Whole state of the block
	typedef struct packed {
		ptvl_pins_t s1; // First sync stage
		ptvl_pins_t s2; // Second sync stage
		logic [NVAR-1:0][VW-1:0] sp; // Trip setpoints
		logic [NVAR-1:0] dir; // Trip direction
		logic [ND-1:0] seal; // Sealed division trips
		logic [ND-1:0] ld_n; // Load driver inputs
		logic [ND-1:0] coil; // Dump relay coils
		logic sol_a; // A solenoid group
		logic sol_b; // B solenoid group
		logic [1:0] dump; // Air dump solenoids
		logic [PTVL_NIRQ-1:0] ist; // Sticky events
		logic [PTVL_NIRQ-1:0] ien; // Event enables
		logic irq; // Interrupt line
		logic aw_have; // Write address held
		logic [PTVL_AW-1:0] awaddr; // Held write address
		logic w_have; // Write data held
		logic [31:0] wdata; // Held write data
		logic [3:0] wstrb; // Held byte strobes
		logic awready; // Address channel ready
		logic wready; // Data channel ready
		logic bvalid; // Write answer valid
		logic [1:0] bresp; // Write answer code
		logic arready; // Read address ready
		logic rvalid; // Read answer valid
		logic [31:0] rdata; // Read data
		logic [1:0] rresp; // Read answer code
	} ptvl_state_t;

	ptvl_state_t st_reg; // Registered state
	ptvl_state_t st_next; // Next state
	logic [NC*NVAR-1:0] var_trip_n; // Comparator outputs, channel major
	logic [ND-1:0] cause_n; // Voting unit trip per division

	// Two-out-of-four vote on active-high trip flags
	function automatic logic two_of_four(input logic [3:0] t);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 4; i++) begin
			n = n + {2'h0, t[i]};
		end
		return n >= 3'h2;
	endfunction

	// ****************************************************************
	// Channel comparators
	// ****************************************************************
	// Every variable against its setpoint; a lost channel trips all
	for (genvar g = 0; g < NC*NVAR; g++) begin : g_cmp
		logic [VW-1:0] v; // Value under test
		logic over; // Beyond setpoint
		assign v = st_reg.s2.val[g*VW +: VW];
		assign over = st_reg.dir[g % NVAR] ? (v >= st_reg.sp[g % NVAR])
			: (v <= st_reg.sp[g % NVAR]);
		assign var_trip_n[g] = st_reg.s2.alive[g / NVAR] & ~over;
	end

	// ****************************************************************
	// Bypass and voting units, one per division
	// ****************************************************************
	for (genvar d = 0; d < ND; d++) begin : g_div
		logic [NC-1:0] chb; // Honoured channel bypasses
		logic mslb; // Honoured steamline bypass
		logic [NVAR-1:0] vt; // Voted variable trips
		logic nmt; // Voted neutron monitor trip
		// Keylock bypasses; two channel keys at once honour none
		assign chb = $onehot0(st_reg.s2.sbyp[d*NC +: NC])
			? st_reg.s2.sbyp[d*NC +: NC] : '0;
		// Special steamline bypass only outside run mode
		assign mslb = st_reg.s2.mbyp[d]
			& (st_reg.s2.mode != PTVL_MODE_RUN);
		for (genvar v = 0; v < NVAR; v++) begin : g_var
			logic [NC-1:0] t; // Unbypassed channel trips
			for (genvar c = 0; c < NC; c++) begin : g_ch
				assign t[c] = ~var_trip_n[c*NVAR + v] & ~chb[c];
			end
			if (v == PTVL_MSL_VAR) begin : g_msl
				assign vt[v] = two_of_four(t) & ~mslb;
			end else begin : g_oth
				assign vt[v] = two_of_four(t);
			end
		end
		assign nmt = two_of_four(~st_reg.s2.nm_n);
		assign cause_n[d] = ~(|vt | nmt);
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		logic vu_ok; // Only one division may be bypassed
		logic [ND-1:0] cause; // Division trip demand
		logic [PTVL_NMAN-1:0] man; // Manual scram per division
		logic auto_a; // Automatic scram vote
		logic auto_d; // Automatic dump vote
		logic [PTVL_NIRQ-1:0] ev; // New events
		logic [PTVL_NIRQ-1:0] clr; // Software clears
		logic wr; // Write performed
		logic wok; // Write address mapped
		logic [PTVL_AW-1:0] ra; // Read address
		vu_ok = 1'b0;
		cause = '0;
		man = '0;
		auto_a = 1'b0;
		auto_d = 1'b0;
		ev = '0;
		clr = '0;
		wr = 1'b0;
		wok = 1'b0;
		ra = '0;
		st_next = st_reg;
		// Pins pass two flip-flops
		st_next.s1.val = chan_value_i;
		st_next.s1.alive = chan_alive_i;
		st_next.s1.nm_n = nm_trip_n_i;
		st_next.s1.mode = mode_i;
		st_next.s1.sbyp = sens_byp_i;
		st_next.s1.mbyp = msl_byp_i;
		st_next.s1.vbyp = vu_byp_i;
		st_next.s1.rst = div_reset_i;
		st_next.s1.test_n = trip_test_n_i;
		st_next.s1.perm = reset_perm_i;
		st_next.s1.man_n = man_scram_n_i;
		st_next.s2 = st_reg.s1;

		// Output units: trip, test, seal-in and permitted reset
		vu_ok = $onehot0(st_reg.s2.vbyp);
		for (int d = 0; d < ND; d++) begin
			cause[d] = ~cause_n[d] | ~st_reg.s2.test_n[d];
			if (vu_ok && st_reg.s2.vbyp[d]) begin
				// Bypassed voting unit cannot trip its division
				cause[d] = 1'b0;
			end
			if (cause[d]) begin
				st_next.seal[d] = 1'b1;
			end else if (st_reg.s2.rst[d] && st_reg.s2.perm[d]) begin
				st_next.seal[d] = 1'b0;
			end
			ev[d] = st_next.seal[d] & ~st_reg.seal[d];
		end
		// Division actuators follow their own output unit
		st_next.ld_n = ~st_reg.seal;
		st_next.coil = ~st_reg.seal;

		// Manual path reads only its switches and the mode switch
		for (int m = 0; m < PTVL_NMAN; m++) begin
			man[m] = ~st_reg.s2.man_n[m]
				| (st_reg.s2.mode == PTVL_MODE_SHUTDOWN);
		end
		// Two-of-four scram on opened drivers, relays likewise
		auto_a = two_of_four(~st_reg.ld_n);
		auto_d = two_of_four(~st_reg.coil);
		st_next.sol_a = ~auto_a & ~man[0];
		st_next.sol_b = ~auto_a & ~man[1];
		st_next.dump = {2{auto_d | (|man)}};

		// Interrupt events; a set outranks a clear
		ev[PTVL_IRQ_MAN] = |man;
		ev[PTVL_IRQ_LOSS] = ~&st_reg.s2.alive;

		// Write address and data may arrive in either order
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr = s_axi_awaddr[PTVL_AW-1:0];
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_have = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		// Perform the write once both halves are held
		if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
			wr = 1'b1;
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
		end
		if (wr) begin
			unique case (st_reg.awaddr)
				PTVL_IRQ_EN_OFS: begin
					wok = 1'b1;
					if (st_reg.wstrb[0]) begin
						st_next.ien = st_reg.wdata[PTVL_NIRQ-1:0];
					end
				end
				PTVL_IRQ_CLR_OFS: begin
					wok = 1'b1;
					if (st_reg.wstrb[0]) begin
						clr = st_reg.wdata[PTVL_NIRQ-1:0];
					end
				end
				PTVL_TRIP_DIR_OFS: begin
					wok = 1'b1;
					if (st_reg.wstrb[0]) begin
						st_next.dir = st_reg.wdata[NVAR-1:0];
					end
				end
				default: begin
					// Setpoint words, byte lanes honoured
					for (int v = 0; v < NVAR; v++) begin
						if (st_reg.awaddr == PTVL_SETPT_OFS + PTVL_AW'(4*v)) begin
							wok = 1'b1;
							for (int b = 0; b < VW/8; b++) begin
								if (st_reg.wstrb[b]) begin
									st_next.sp[v][b*8 +: 8] = st_reg.wdata[b*8 +: 8];
								end
							end
						end
					end
				end
			endcase
			st_next.bresp = wok ? PTVL_RESP_OKAY : PTVL_RESP_SLVERR;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		st_next.awready = ~st_next.aw_have & ~st_next.bvalid;
		st_next.wready = ~st_next.w_have & ~st_next.bvalid;
		st_next.ist = (st_reg.ist & ~clr) | ev;
		st_next.irq = |(st_reg.ist & st_reg.ien);

		// Read: take address, answer next cycle, hold until taken
		if (s_axi_arvalid && st_reg.arready) begin
			ra = s_axi_araddr[PTVL_AW-1:0];
			st_next.arready = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = PTVL_RESP_OKAY;
			st_next.rdata = PTVL_ZERO_WORD;
			unique case (ra)
				PTVL_STATUS_OFS: begin
					st_next.rdata[PTVL_ST_SEAL +: ND] = st_reg.seal;
					st_next.rdata[PTVL_ST_SOL_A] = st_reg.sol_a;
					st_next.rdata[PTVL_ST_SOL_B] = st_reg.sol_b;
					st_next.rdata[PTVL_ST_DUMP +: 2] = st_reg.dump;
				end
				PTVL_IRQ_STAT_OFS: begin
					st_next.rdata[PTVL_NIRQ-1:0] = st_reg.ist;
				end
				PTVL_IRQ_EN_OFS: begin
					st_next.rdata[PTVL_NIRQ-1:0] = st_reg.ien;
				end
				PTVL_TRIP_DIR_OFS: begin
					st_next.rdata[NVAR-1:0] = st_reg.dir;
				end
				default: begin
					st_next.rresp = PTVL_RESP_SLVERR;
					for (int v = 0; v < NVAR; v++) begin
						if (ra == PTVL_SETPT_OFS + PTVL_AW'(4*v)) begin
							st_next.rresp = PTVL_RESP_OKAY;
							st_next.rdata[VW-1:0] = st_reg.sp[v];
						end
					end
				end
			endcase
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset leaves every division sealed and the actuators tripped
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.seal <= '1;
			st_reg.dump <= '1;
			st_reg.arready <= 1'b1;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Outputs straight from flip-flops
	// ****************************************************************
	assign ld_trip_n_o = st_reg.ld_n;
	assign relay_coil_o = st_reg.coil;
	assign sol_a_o = st_reg.sol_a;
	assign sol_b_o = st_reg.sol_b;
	assign dump_sol_o = st_reg.dump;
	assign irq_o = st_reg.irq;
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
endmodule
`default_nettype wire
